/* File: hdl/dpm_regs.vh */
// Register offsets, field positions and reset values of the debug port mailbox.
//
// What this block does and what software and the debugger must do
// R01 - Control upper byte and bit five always read zero regardless of writes.
// R02 - Bit 7 zero: reading incoming register 1 clears its flag; one: software clears.
// R03 - Bit 6 zero: reading incoming register 0 clears its flag; one: software clears.
// R04 - Bit 4 selects 16-bit transfers (slot 0 only) or 32-bit (both slots).
// R05 - Outgoing ready flag 1 clears when its high byte or word is written.
// R06 - Outgoing ready flag 0 clears when its high byte or word is written.
// R07 - Each outgoing ready flag sets again once the debugger reads that message.
// R08 - Incoming new-data flag 0 or 1 sets when the debugger deposits a message.
// R09 - Incoming registers: 16 bits, CPU read-only, high and low byte, reset zero.
// R10 - Outgoing registers: 16 bits, CPU read-write, high and low byte, reset zero.
// R11 - Control register reads 000Ch after reset.
// R12 - Software pads and drains partial messages before changing the transfer width.
// R13 - Debugger writes after CPU consumes, reads outgoing only while ready is clear.
`ifndef DPM_REGS_VH
`define DPM_REGS_VH

`define DPM_OFS_CONTROL    8'h06
`define DPM_OFS_IN0        8'h08
`define DPM_OFS_IN1        8'h0a
`define DPM_OFS_OUT0       8'h0c
`define DPM_OFS_OUT1       8'h0e
`define DPM_OFS_EVENTS     8'h10
`define DPM_OFS_EVMASK     8'h12

`define DPM_BIT_IN0_FLAG   0
`define DPM_BIT_IN1_FLAG   1
`define DPM_BIT_OUT0_FLAG  2
`define DPM_BIT_OUT1_FLAG  3
`define DPM_BIT_WIDTH_SEL  4
`define DPM_BIT_IN0_ACOFF  6
`define DPM_BIT_IN1_ACOFF  7

`define DPM_RST_CONTROL    16'h000c
`define DPM_RST_MESSAGE    16'h0000
`define DPM_RST_EVENTS     4'h0
`define DPM_RST_EVMASK     4'h0

`endif

/* File: hdl/dpm_mailbox.v */
// Debug port mailbox: CPU register port, debugger link and event interrupt.
`timescale 1ns/100ps
`default_nettype none
`include "dpm_regs.vh"

module dpm_mailbox
(
  input  wire        sys_clk,
  input  wire        rstn,
  input  wire [7:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  input  wire [1:0]  reg_wr_be,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [15:0] reg_rdata,
  output reg         irq,
  input  wire        dbg_clk,
  input  wire        dbg_wr,
  input  wire        dbg_rd,
  input  wire        dbg_sel,
  input  wire [15:0] dbg_wdata,
  output reg  [15:0] dbg_rdata,
  output reg  [3:0]  dbg_flags
);

  // ************************************************************
  // Functions
  // ************************************************************

  // Merges write data into a 16-bit register under byte enables.
  function [15:0] merge_bytes;
    input [15:0] old_val;
    input [15:0] new_val;
    input [1:0]  be;
    begin
      merge_bytes = old_val;
      if (be[0])
        merge_bytes[7:0] = new_val[7:0];
      if (be[1])
        merge_bytes[15:8] = new_val[15:8];
    end
  endfunction

  // ************************************************************
  // Declarations
  // ************************************************************

  reg  [15:0] in_msg0;
  reg  [15:0] in_msg1;
  reg  [15:0] out_msg0;
  reg  [15:0] out_msg1;
  reg         in0_new_data_flag;
  reg         in1_new_data_flag;
  reg         out0_ready_flag;
  reg         out1_ready_flag;
  reg         transfer_width_select;
  reg         in0_autoclear_disable;
  reg         in1_autoclear_disable;
  reg  [3:0]  ev_status;
  reg  [3:0]  ev_mask;
  reg  [19:0] link_s1;
  reg  [19:0] link_s2;
  reg         link_clk_d;

  wire        link_clk_s;
  wire        link_wr_s;
  wire        link_rd_s;
  wire        link_sel_s;
  wire [15:0] link_data_s;
  wire        link_edge;
  wire        slot1_ok;
  wire        dep0;
  wire        dep1;
  wire        took0;
  wire        took1;
  wire        wr_ctrl;
  wire        wr_out0;
  wire        wr_out1;
  wire        wr_mask;
  wire        rd_in0;
  wire        rd_in1;
  wire        rd_events;
  wire [15:0] ctrl_view;
  wire [3:0]  ev_set;

  reg  [15:0] next_reg_rdata;

  // ************************************************************
  // Link input synchroniser
  // ************************************************************

  // Every link input passes two flops; edges are found on the second.
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      link_s1    <= 20'h00000;
      link_s2    <= 20'h00000;
      link_clk_d <= 1'b0;
    end
    else
    begin
      link_s1    <= {dbg_clk, dbg_wr, dbg_rd, dbg_sel, dbg_wdata};
      link_s2    <= link_s1;
      link_clk_d <= link_s2[19];
    end
  end

  assign link_clk_s  = link_s2[19];
  assign link_wr_s   = link_s2[18];
  assign link_rd_s   = link_s2[17];
  assign link_sel_s  = link_s2[16];
  assign link_data_s = link_s2[15:0];
  assign link_edge   = link_clk_s & ~link_clk_d;

  // Slot 1 only takes part in 32-bit transfers.
  assign slot1_ok = transfer_width_select; // R04
  assign dep0     = link_edge & link_wr_s & ~link_sel_s;
  assign dep1     = link_edge & link_wr_s & link_sel_s & slot1_ok;
  assign took0    = link_edge & link_rd_s & ~link_sel_s;
  assign took1    = link_edge & link_rd_s & link_sel_s & slot1_ok;

  // ************************************************************
  // Register decode
  // ************************************************************

  assign wr_ctrl   = reg_wr & (reg_addr == `DPM_OFS_CONTROL);
  assign wr_out0   = reg_wr & (reg_addr == `DPM_OFS_OUT0);
  assign wr_out1   = reg_wr & (reg_addr == `DPM_OFS_OUT1);
  assign wr_mask   = reg_wr & (reg_addr == `DPM_OFS_EVMASK) & reg_wr_be[0];
  assign rd_in0    = reg_rd & (reg_addr == `DPM_OFS_IN0);
  assign rd_in1    = reg_rd & (reg_addr == `DPM_OFS_IN1);
  assign rd_events = reg_rd & (reg_addr == `DPM_OFS_EVENTS);

  // Upper byte and bit five are held at zero.
  assign ctrl_view = {8'h00,                  // R01
                      in1_autoclear_disable,
                      in0_autoclear_disable,
                      1'b0,                   // R01
                      transfer_width_select,
                      out1_ready_flag,
                      out0_ready_flag,
                      in1_new_data_flag,
                      in0_new_data_flag};

  // ************************************************************
  // Incoming messages
  // ************************************************************

  // The debugger deposits messages; the CPU only reads them.
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      in_msg0 <= `DPM_RST_MESSAGE; // R09
      in_msg1 <= `DPM_RST_MESSAGE; // R09
    end
    else
    begin
      if (dep0)
        in_msg0 <= link_data_s;
      if (dep1)
        in_msg1 <= link_data_s;
    end
  end

  // A deposit in the same cycle as a clear leaves the flag set.
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      in0_new_data_flag <= 1'b0; // R11
      in1_new_data_flag <= 1'b0; // R11
    end
    else
    begin
      if (dep0)
        in0_new_data_flag <= 1'b1; // R08
      else if (wr_ctrl && reg_wr_be[0])
        in0_new_data_flag <= reg_wdata[`DPM_BIT_IN0_FLAG];
      else if (rd_in0 && !in0_autoclear_disable)
        in0_new_data_flag <= 1'b0; // R03
      if (dep1)
        in1_new_data_flag <= 1'b1; // R08
      else if (wr_ctrl && reg_wr_be[0])
        in1_new_data_flag <= reg_wdata[`DPM_BIT_IN1_FLAG];
      else if (rd_in1 && !in1_autoclear_disable)
        in1_new_data_flag <= 1'b0; // R02
    end
  end

  // ************************************************************
  // Control bits
  // ************************************************************

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      transfer_width_select <= 1'b0; // R11
      in0_autoclear_disable <= 1'b0; // R11
      in1_autoclear_disable <= 1'b0; // R11
    end
    else if (wr_ctrl && reg_wr_be[0])
    begin
      transfer_width_select <= reg_wdata[`DPM_BIT_WIDTH_SEL]; // R04
      in0_autoclear_disable <= reg_wdata[`DPM_BIT_IN0_ACOFF]; // R03
      in1_autoclear_disable <= reg_wdata[`DPM_BIT_IN1_ACOFF]; // R02
    end
  end

  // ************************************************************
  // Outgoing messages
  // ************************************************************

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      out_msg0 <= `DPM_RST_MESSAGE; // R10
      out_msg1 <= `DPM_RST_MESSAGE; // R10
    end
    else
    begin
      if (wr_out0)
        out_msg0 <= merge_bytes(out_msg0, reg_wdata, reg_wr_be); // R10
      if (wr_out1)
        out_msg1 <= merge_bytes(out_msg1, reg_wdata, reg_wr_be); // R10
    end
  end

  // Only a write that reaches the high byte hands the slot over.
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      out0_ready_flag <= 1'b1; // R11
      out1_ready_flag <= 1'b1; // R11
    end
    else
    begin
      if (took0)
        out0_ready_flag <= 1'b1; // R07
      else if (wr_out0 && reg_wr_be[1])
        out0_ready_flag <= 1'b0; // R06
      if (took1)
        out1_ready_flag <= 1'b1; // R07
      else if (wr_out1 && reg_wr_be[1])
        out1_ready_flag <= 1'b0; // R05
    end
  end

  // ************************************************************
  // Debugger read path
  // ************************************************************

  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dbg_rdata <= `DPM_RST_MESSAGE;
      dbg_flags <= 4'hc;
    end
    else
    begin
      if (took0)
        dbg_rdata <= out_msg0;
      else if (took1)
        dbg_rdata <= out_msg1;
      dbg_flags <= {out1_ready_flag, out0_ready_flag,
                    in1_new_data_flag, in0_new_data_flag};
    end
  end

  // ************************************************************
  // Events and interrupt
  // ************************************************************

  assign ev_set = {took1, took0, dep1, dep0};

  // A read clears the events it returned; new events in that cycle survive.
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ev_status <= `DPM_RST_EVENTS;
      ev_mask   <= `DPM_RST_EVMASK;
      irq       <= 1'b0;
    end
    else
    begin
      if (rd_events)
        ev_status <= ev_set;
      else
        ev_status <= ev_status | ev_set;
      if (wr_mask)
        ev_mask <= reg_wdata[3:0];
      irq <= |(ev_status & ev_mask);
    end
  end

  // ************************************************************
  // CPU read data
  // ************************************************************

  always @*
  begin
    next_reg_rdata = 16'h0000;
    if (reg_rd)
    begin
      case (reg_addr)
        `DPM_OFS_CONTROL: next_reg_rdata = ctrl_view;
        `DPM_OFS_IN0:     next_reg_rdata = in_msg0;  // R09
        `DPM_OFS_IN1:     next_reg_rdata = in_msg1;  // R09
        `DPM_OFS_OUT0:    next_reg_rdata = out_msg0; // R10
        `DPM_OFS_OUT1:    next_reg_rdata = out_msg1; // R10
        `DPM_OFS_EVENTS:  next_reg_rdata = {12'h000, ev_status};
        `DPM_OFS_EVMASK:  next_reg_rdata = {12'h000, ev_mask};
        default:          next_reg_rdata = 16'h0000;
      endcase
    end
  end

  // Read data stand for exactly one cycle after the strobe.
  always @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 16'h0000;
    else
      reg_rdata <= next_reg_rdata;
  end

endmodule // dpm_mailbox
`default_nettype wire

/* File: verif/dpm_mailbox_monitor.sv */
// Checker of the debug port mailbox register and link behaviour.
`timescale 1ns/100ps
`default_nettype none
module dpm_mailbox_monitor
(
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic [7:0]  reg_addr,
  input wire logic [1:0]  reg_wr_be,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        dbg_wr,
  input wire logic        dbg_rd,
  input wire logic [3:0]  dbg_flags
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_hi_wr(a);
    reg_wr && reg_addr == a && reg_wr_be[1];
  endsequence
  sequence s_rd(a);
    reg_rd && reg_addr == a;
  endsequence
  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  chk_ctrl_zeros: assert property (s_rd(8'h06) |=>
    reg_rdata[15:8] == 8'h00 && !reg_rdata[5]) else $error("control reserved bits set");
  chk_out0_clear: assert property (s_hi_wr(8'h0c) |-> ##2 !dbg_flags[2])
    else $error("out0 ready not cleared");
  chk_out1_clear: assert property (s_hi_wr(8'h0e) |-> ##2 !dbg_flags[3])
    else $error("out1 ready not cleared");
  chk_in0_set: assert property ($rose(dbg_flags[0]) |->
    $past(dbg_wr, 4) || $past(reg_wr, 2)) else $error("in0 flag set without cause");
  chk_out0_set: assert property ($rose(dbg_flags[2]) |-> $past(dbg_rd, 4))
    else $error("out0 ready set without a read");
  chk_in0_clear: assert property ($fell(dbg_flags[0]) |-> $past(reg_addr, 2) == 8'h08
    && $past(reg_rd, 2) || $past(reg_addr, 2) == 8'h06 && $past(reg_wr, 2))
    else $error("in0 flag cleared without cause");
  chk_in1_clear: assert property ($fell(dbg_flags[1]) |-> $past(reg_addr, 2) == 8'h0a
    && $past(reg_rd, 2) || $past(reg_addr, 2) == 8'h06 && $past(reg_wr, 2))
    else $error("in1 flag cleared without cause");
endmodule // dpm_mailbox_monitor
bind dpm_mailbox dpm_mailbox_monitor mon_u (.sys_clk(sys_clk), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wr_be(reg_wr_be), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .dbg_wr(dbg_wr), .dbg_rd(dbg_rd), .dbg_flags(dbg_flags));
`default_nettype wire

/* File: verif/dpm_debugger.sv */
// Behavioural debugger that moves messages over the mailbox link.
`timescale 1ns/100ps
`default_nettype none
module dpm_debugger
(
  output var logic        dbg_clk,
  output var logic        dbg_wr,
  output var logic        dbg_rd,
  output var logic        dbg_sel,
  output var logic [15:0] dbg_wdata,
  input  wire logic [15:0] dbg_rdata
);
  logic [15:0] last_rd;
  initial
  begin
    dbg_clk = 1'b0;
    dbg_wr = 1'b0;
    dbg_rd = 1'b0;
    dbg_sel = 1'b0;
    dbg_wdata = 16'h0000;
    last_rd = 16'h0000;
  end
  // The link clock runs only inside a frame; released data shows the inverse value.
  // Called on a rising system clock edge; every change lands on such an edge by
  // non-blocking assignment, so the synchroniser never races the link pins.
  task automatic xfer(input logic wr, input logic rd, input logic sel, input logic [15:0] d);
    dbg_wr <= wr;
    dbg_rd <= rd;
    dbg_sel <= sel;
    dbg_wdata <= d;
    #40 dbg_clk <= 1'b1;
    #40 dbg_clk <= 1'b0;
    #40 dbg_wr <= 1'b0;
    dbg_rd <= 1'b0;
    dbg_wdata <= ~d;
    #40 last_rd = dbg_rdata;
  endtask
endmodule // dpm_debugger
`default_nettype wire

/* File: verif/test_dpm_mailbox.sv */
// Self-checking bench of the debug port mailbox.
`timescale 1ns/100ps
`default_nettype none
module test_dpm_mailbox;
  logic        sys_clk;
  logic        rstn;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic [1:0]  reg_wr_be;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        irq;
  logic        dbg_clk;
  logic        dbg_wr;
  logic        dbg_rd;
  logic        dbg_sel;
  logic [15:0] dbg_wdata;
  logic [15:0] dbg_rdata;
  logic [3:0]  dbg_flags;
  int          fail_count;
  int          num_checks;
  dpm_mailbox dut_u (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr_be(reg_wr_be), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq(irq), .dbg_clk(dbg_clk), .dbg_wr(dbg_wr), .dbg_rd(dbg_rd),
    .dbg_sel(dbg_sel), .dbg_wdata(dbg_wdata), .dbg_rdata(dbg_rdata), .dbg_flags(dbg_flags));
  dpm_debugger deb_u (.dbg_clk(dbg_clk), .dbg_wr(dbg_wr), .dbg_rd(dbg_rd),
    .dbg_sel(dbg_sel), .dbg_wdata(dbg_wdata), .dbg_rdata(dbg_rdata));
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr_be <= be;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic chk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 cmp16(reg_rdata, exp);
  endtask
  task automatic link(input logic w, input logic sel, input logic [15:0] d);
    @(posedge sys_clk);
    deb_u.xfer(w, !w, sel, d);
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #100000;
    fail_count++;
    tally_and_finish;
  end
  initial
  begin
    fail_count = 0;
    num_checks = 0;
    rstn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    reg_wr_be = 2'b00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    chk(8'h06, 16'h000c);
    cmp16({12'h000, dbg_flags}, 16'h000c);
    for (int i = 0; i < 4; i++)
      chk(8'h08 + 8'(2 * i), 16'h0000);
    chk(8'h14, 16'h0000);
    wr(8'h06, 16'hffff, 2'b11);
    chk(8'h06, 16'h00df);
    wr(8'h06, 16'h0000, 2'b11);
    chk(8'h06, 16'h000c);
    link(1'b1, 1'b0, 16'ha55a);
    chk(8'h06, 16'h000d);
    chk(8'h08, 16'ha55a);
    chk(8'h06, 16'h000c);
    link(1'b1, 1'b1, 16'h1234);
    chk(8'h0a, 16'h0000);
    wr(8'h06, 16'h0010, 2'b11);
    link(1'b1, 1'b1, 16'h1234);
    chk(8'h06, 16'h001e);
    chk(8'h0a, 16'h1234);
    chk(8'h06, 16'h001c);
    wr(8'h06, 16'h00d0, 2'b11);
    link(1'b1, 1'b0, 16'hbeef);
    wr(8'h08, 16'h0000, 2'b11);
    chk(8'h08, 16'hbeef);
    chk(8'h06, 16'h00dd);
    link(1'b1, 1'b1, 16'h4321);
    chk(8'h0a, 16'h4321);
    chk(8'h06, 16'h00df);
    wr(8'h06, 16'h00d0, 2'b01);
    chk(8'h06, 16'h00dc);
    wr(8'h06, 16'hffff, 2'b10);
    chk(8'h06, 16'h00dc);
    wr(8'h0c, 16'hff77, 2'b01);
    chk(8'h06, 16'h00dc);
    chk(8'h0c, 16'h0077);
    wr(8'h0c, 16'hc3c3, 2'b11);
    wr(8'h0e, 16'h5aa5, 2'b10);
    chk(8'h06, 16'h00d0);
    cmp16({12'h000, dbg_flags}, 16'h0000);
    chk(8'h0e, 16'h5a00);
    link(1'b0, 1'b0, 16'h0000);
    cmp16(deb_u.last_rd, 16'hc3c3);
    chk(8'h06, 16'h00d4);
    link(1'b0, 1'b1, 16'h0000);
    cmp16(deb_u.last_rd, 16'h5a00);
    chk(8'h06, 16'h00dc);
    cmp16({12'h000, dbg_flags}, 16'h000c);
    chk(8'h10, 16'h000f);
    chk(8'h10, 16'h0000);
    wr(8'h12, 16'h0001, 2'b01);
    link(1'b1, 1'b0, 16'h0f0f);
    cmp16({15'h0000, irq}, 16'h0001);
    wr(8'h12, 16'h0000, 2'b01);
    repeat (3) @(negedge sys_clk);
    cmp16({15'h0000, irq}, 16'h0000);
    wr(8'h12, 16'h0001, 2'b01);
    chk(8'h10, 16'h0001);
    repeat (3) @(negedge sys_clk);
    cmp16({15'h0000, irq}, 16'h0000);
    chk(8'h12, 16'h0001);
    tally_and_finish;
  end
endmodule // test_dpm_mailbox
`default_nettype wire
